// ---- hdl/fpp_ctrl.sv ----
/*
 Program flash control and protection: unlock keys, control/status, option
 bits, 32-byte write latch, mode check and serial-link entry detection.
 Assumes a flash array on core_clk_i that takes one request pulse and
 answers with a done pulse, and a programming tool driving the link pins.
*/
// Operation
// - program single byte or 32-byte row
// - sector erase touches only its sector
// - tool modes may alter sectors 0, 1
// - in-application mode keeps sector 0 locked
// - serial entry boots from system memory
// - 38 pulses force RC; 35 uses external clock
// - reset returns link clock pin to pull-up input
// - readout protection blocks extraction and writes
// - removing readout protection mass-erases first
// - readout protection only via its option bit
// - write/erase protection refuses program and sector erase
// - write/erase protection clears only at core reset
// - control/status register resets to zero
// - both protections selectable independently
`timescale 1ns/1ps
`include "fpp_consts.svh"
module fpp_ctrl #(
  parameter int ADDR_W = 13,
  parameter int SECT0_BYTES = 4096,
  parameter int LATCH_BYTES = 32
) (
  // clocks and resets
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic link_resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pins
  input wire logic rst_pin_n_i,
  input wire logic prog_link_data_pin_i,
  input wire logic socket_mode_i,
  output logic prog_link_clock_pin_o,
  output logic prog_link_clock_pin_oe_o,
  output logic prog_link_clock_pullup_o,
  // flash array
  output fpp_pkg::fpp_req_type nvm_req_o,
  output logic nvm_req_valid_o,
  input wire logic nvm_done_i,
  // system
  output logic boot_sysmem_o,
  output logic clk_force_rc_o,
  output logic clk_ext_sel_o,
  output logic extract_block_o
);
  if (LATCH_BYTES != 32 || ADDR_W < 9 || ADDR_W > 13 || SECT0_BYTES < 32 ||
      SECT0_BYTES >= (1 << ADDR_W)) begin : g_chk
    $error("fpp_ctrl: unsupported parameters");
  end

  // link domain: count link clock pulses while reset pin low and data high
  logic [1:0] link_rst_sync;
  logic [1:0] link_dat_sync;
  logic [5:0] pulse_bin;
  logic [5:0] pulse_gray;
  wire link_rst_low = ~link_rst_sync[1];
  wire link_count = link_rst_low & link_dat_sync[1] & (pulse_bin != 6'h3F);
  wire [5:0] next_pulse_bin = link_rst_low ? pulse_bin + (link_count ? 6'h01 : 6'h00)
                                           : 6'h00;

  always_ff @(posedge link_clk_i or negedge link_resetn_i) begin
    if (!link_resetn_i) begin
      link_rst_sync <= 2'h0;
      link_dat_sync <= 2'h0;
      pulse_bin <= 6'h00;
      pulse_gray <= 6'h00;
    end else begin
      link_rst_sync <= {link_rst_sync[0], rst_pin_n_i};
      link_dat_sync <= {link_dat_sync[0], prog_link_data_pin_i};
      pulse_bin <= next_pulse_bin;
      pulse_gray <= next_pulse_bin ^ (next_pulse_bin >> 1);
    end
  end

  // core domain: gray count crosses bit by bit, value moves by one step except the clear to zero once the reset pin is high
  logic [5:0] gray_s1;
  logic [5:0] gray_s2;
  logic [1:0] sock_sync;
  logic [1:0] settle;
  logic mode_taken;
  fpp_pkg::fpp_mode_type mode;

  function automatic logic [5:0] gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b = g;
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  wire [5:0] pulse_core = gray2bin(gray_s2);
  wire is_38 = pulse_core == `FPP_ENTRY_38;
  wire is_35 = pulse_core == `FPP_ENTRY_35;
  wire capture = ~mode_taken & (settle == `FPP_SETTLE);
  wire fpp_pkg::fpp_mode_type next_mode =
    is_38 ? fpp_pkg::FPP_MODE_SER38 :
    is_35 ? fpp_pkg::FPP_MODE_SER35 :
    sock_sync[1] ? fpp_pkg::FPP_MODE_TOOL : fpp_pkg::FPP_MODE_APP;

  // entry is caught as a strap once the syncs have filled after release
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gray_s1 <= 6'h00;
      gray_s2 <= 6'h00;
      sock_sync <= 2'h0;
      settle <= 2'h0;
      mode_taken <= 1'b0;
      mode <= fpp_pkg::FPP_MODE_APP;
    end else begin
      gray_s1 <= pulse_gray;
      gray_s2 <= gray_s1;
      sock_sync <= {sock_sync[0], socket_mode_i};
      settle <= (settle == `FPP_SETTLE) ? settle : settle + 2'h1;
      mode_taken <= mode_taken | capture;
      if (capture) begin
        mode <= next_mode;
      end
    end
  end

  wire mode_ser = mode == fpp_pkg::FPP_MODE_SER35 || mode == fpp_pkg::FPP_MODE_SER38;
  wire mode_ext = mode_ser || mode == fpp_pkg::FPP_MODE_TOOL;
  assign boot_sysmem_o = mode_taken & mode_ser;
  assign clk_force_rc_o = mode_taken & (mode == fpp_pkg::FPP_MODE_SER38);
  assign clk_ext_sel_o = mode_taken & (mode == fpp_pkg::FPP_MODE_SER35);

  // register decode
  wire wr_csr = reg_wr_i & (reg_addr_i == `FPP_ADDR_CSR);
  wire wr_key = reg_wr_i & (reg_addr_i == `FPP_ADDR_KEY);
  wire wr_opt = reg_wr_i & (reg_addr_i == `FPP_ADDR_OPT);
  wire wr_adrh = reg_wr_i & (reg_addr_i == `FPP_ADDR_ADRH);
  wire wr_adrl = reg_wr_i & (reg_addr_i == `FPP_ADDR_ADRL);
  wire wr_data = reg_wr_i & (reg_addr_i == `FPP_ADDR_DATA);
  wire wr_stat = reg_wr_i & (reg_addr_i == `FPP_ADDR_STAT);
  wire wr_pin = reg_wr_i & (reg_addr_i == `FPP_ADDR_PIN);

  // unlock keys: the second key must be the very next register write
  fpp_pkg::fpp_key_type key_state;
  wire key_open = key_state == fpp_pkg::FPP_KEY_OPEN;
  wire fpp_pkg::fpp_key_type next_key_state =
    (wr_key && reg_wdata_i == `FPP_KEY1 && key_state != fpp_pkg::FPP_KEY_OPEN) ?
      fpp_pkg::FPP_KEY_HALF :
    (wr_key && reg_wdata_i == `FPP_KEY2 && key_state == fpp_pkg::FPP_KEY_HALF) ?
      fpp_pkg::FPP_KEY_OPEN :
    (reg_wr_i && key_state == fpp_pkg::FPP_KEY_HALF) ? fpp_pkg::FPP_KEY_LOCKED :
    key_state;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_state <= fpp_pkg::FPP_KEY_LOCKED;
    end else begin
      key_state <= next_key_state;
    end
  end

  // address, latch and options
  logic [ADDR_W-1:0] flash_addr;
  logic [7:0] latch_mem [LATCH_BYTES];
  logic [LATCH_BYTES-1:0] latch_mask;
  logic rop;
  logic wep;
  logic [7:0] csr;
  logic refused;
  logic pin_oe;
  logic pin_lvl;
  fpp_pkg::fpp_state_type seq;
  fpp_pkg::fpp_op_type op;
  logic op_sector;

  wire busy = seq != fpp_pkg::FPP_SEQ_IDLE;
  wire lat_on = csr[`FPP_CSR_LAT];
  wire [4:0] byte_sel = flash_addr[4:0];
  wire addr_sect0 = 32'(flash_addr) < SECT0_BYTES;
  // sector 0 only from a tool; program and sector erase refused under either protection
  wire sect_ok = mode_ext | ~addr_sect0;
  wire prot_ok = ~rop & ~wep;
  wire csr_ok = wr_csr & key_open & ~busy;
  wire want_pgm = csr_ok & reg_wdata_i[`FPP_CSR_PGM] & lat_on & (latch_mask != '0);
  wire want_ser = csr_ok & reg_wdata_i[`FPP_CSR_SER] & ~reg_wdata_i[`FPP_CSR_PGM];
  wire op_ok = sect_ok & prot_ok;
  wire start_op = (want_pgm | want_ser) & op_ok;
  wire refuse_op = (want_pgm | want_ser) & ~op_ok;
  // readout option only through its bit, and only from a tool once unlocked
  wire opt_ok = wr_opt & key_open & mode_ext & ~busy;
  wire rop_clear_req = opt_ok & rop & ~reg_wdata_i[`FPP_OPT_ROP];
  wire mass_done = seq == fpp_pkg::FPP_SEQ_WAIT && op == fpp_pkg::FPP_OP_MASS && nvm_done_i;
  wire op_done = seq == fpp_pkg::FPP_SEQ_WAIT && nvm_done_i;

  // write latch keeps earlier bytes of the row until program ends or a CSR write clears lat
  always_ff @(posedge core_clk_i) begin
    if (wr_data && lat_on && !busy) begin
      latch_mem[byte_sel] <= reg_wdata_i;
    end
  end

  wire lat_fall = wr_csr & key_open & ~busy & ~reg_wdata_i[`FPP_CSR_LAT];
  wire [LATCH_BYTES-1:0] byte_onehot = LATCH_BYTES'(1) << byte_sel;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_addr <= '0;
      latch_mask <= '0;
    end else begin
      if (wr_adrh && !busy) begin
        flash_addr[ADDR_W-1:8] <= reg_wdata_i[ADDR_W-9:0];
      end
      if (wr_adrl && !busy) begin
        flash_addr[7:0] <= reg_wdata_i;
      end
      if ((op_done && op == fpp_pkg::FPP_OP_PROG) || lat_fall) begin
        latch_mask <= '0;
      end else if (wr_data && lat_on && !busy) begin
        latch_mask <= latch_mask | byte_onehot;
      end
    end
  end

  // option bits: write/erase protection only sets from a write; core reset clears it
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rop <= 1'b0;
      wep <= 1'b0;
    end else begin
      wep <= wep | (opt_ok & reg_wdata_i[`FPP_OPT_WEP]);
      if (opt_ok && reg_wdata_i[`FPP_OPT_ROP]) begin
        rop <= 1'b1;
      end else if (mass_done) begin
        rop <= 1'b0;
      end
    end
  end
  assign extract_block_o = rop;

  // sequencer: one request pulse, then wait for the array
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq <= fpp_pkg::FPP_SEQ_IDLE;
      op <= fpp_pkg::FPP_OP_NONE;
      op_sector <= 1'b0;
    end else begin
      unique case (seq)
        fpp_pkg::FPP_SEQ_IDLE: begin
          if (rop_clear_req) begin
            seq <= fpp_pkg::FPP_SEQ_ISSUE;
            op <= fpp_pkg::FPP_OP_MASS;
          end else if (start_op) begin
            seq <= fpp_pkg::FPP_SEQ_ISSUE;
            op <= want_pgm ? fpp_pkg::FPP_OP_PROG : fpp_pkg::FPP_OP_SECT;
            op_sector <= ~addr_sect0;
          end
        end
        fpp_pkg::FPP_SEQ_ISSUE: begin
          seq <= fpp_pkg::FPP_SEQ_WAIT;
        end
        fpp_pkg::FPP_SEQ_WAIT: begin
          if (nvm_done_i) begin
            seq <= fpp_pkg::FPP_SEQ_IDLE;
            op <= fpp_pkg::FPP_OP_NONE;
          end
        end
        default: begin
          seq <= fpp_pkg::FPP_SEQ_IDLE;
        end
      endcase
    end
  end

  // request carrier to the array, held stable while busy
  logic [255:0] latch_flat;
  always_comb begin
    latch_flat = '0;
    for (int i = 0; i < LATCH_BYTES; i++) begin
      latch_flat[i*8 +: 8] = latch_mem[i];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nvm_req_o <= '0;
      nvm_req_valid_o <= 1'b0;
    end else begin
      nvm_req_valid_o <= (seq == fpp_pkg::FPP_SEQ_IDLE) & (rop_clear_req | start_op);
      if (seq == fpp_pkg::FPP_SEQ_IDLE && (rop_clear_req || start_op)) begin
        nvm_req_o.op <= rop_clear_req ? fpp_pkg::FPP_OP_MASS :
                        want_pgm ? fpp_pkg::FPP_OP_PROG : fpp_pkg::FPP_OP_SECT;
        nvm_req_o.sector <= ~addr_sect0;
        nvm_req_o.row <= 8'(flash_addr >> 5);
        nvm_req_o.mask <= want_pgm ? latch_mask : '0;
        nvm_req_o.data <= latch_flat;
      end
    end
  end

  // control/status: pgm and ser clear at done, lat follows pgm
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      csr <= `FPP_CSR_RST;
    end else if (op_done && op != fpp_pkg::FPP_OP_MASS) begin
      csr <= `FPP_CSR_RST;
    end else if (csr_ok) begin
      csr <= {5'h00, reg_wdata_i[2:0] & {start_op, 1'b1, start_op}};
    end
  end

  // refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      refused <= 1'b0;
    end else if (refuse_op) begin
      refused <= 1'b1;
    end else if (wr_stat && reg_wdata_i[`FPP_STAT_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // core reset (resetn_i) gives the pin back as an input with pull-up; link reset leaves it alone
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_oe <= 1'b0;
      pin_lvl <= 1'b0;
    end else if (wr_pin) begin
      pin_oe <= reg_wdata_i[`FPP_PIN_OE];
      pin_lvl <= reg_wdata_i[`FPP_PIN_LVL];
    end
  end
  assign prog_link_clock_pin_oe_o = pin_oe;
  assign prog_link_clock_pin_o = pin_lvl;
  assign prog_link_clock_pullup_o = ~pin_oe;

  // read mux; latch contents are write-only
  wire [7:0] rd_mux =
    (reg_addr_i == `FPP_ADDR_CSR) ? csr :
    (reg_addr_i == `FPP_ADDR_OPT) ? {6'h00, wep, rop} :
    (reg_addr_i == `FPP_ADDR_ADRH) ? 8'(flash_addr >> 8) :
    (reg_addr_i == `FPP_ADDR_ADRL) ? flash_addr[7:0] :
    (reg_addr_i == `FPP_ADDR_STAT) ? {3'h0, refused, busy, key_open, mode} :
    (reg_addr_i == `FPP_ADDR_PIN) ? {6'h00, pin_lvl, pin_oe} : 8'h00;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  // checks
  wp_never_clears_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(wep) |-> 1'b0) else $error("write/erase protection cleared");
  app_sect0_locked_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (mode_taken && !mode_ext && addr_sect0 && (want_pgm || want_ser) && !busy)
    |=> !nvm_req_valid_o && refused) else $error("sector 0 change in application");
  tool_sect0_ok_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (mode_ext && addr_sect0 && want_ser && !rop && !wep && !busy && !rop_clear_req)
    |=> nvm_req_valid_o && nvm_req_o.op == fpp_pkg::FPP_OP_SECT && !nvm_req_o.sector)
    else $error("tool sector 0 erase not issued");
  prot_refuse_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    nvm_req_valid_o && nvm_req_o.op != fpp_pkg::FPP_OP_MASS |-> !$past(rop) && !$past(wep))
    else $error("flash change under protection");
  rop_mass_first_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(rop) |-> $past(op) == fpp_pkg::FPP_OP_MASS && $past(nvm_done_i))
    else $error("readout removed without mass erase");
  key_order_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (key_state == fpp_pkg::FPP_KEY_LOCKED && !(wr_key && reg_wdata_i == `FPP_KEY1))
    |=> !key_open) else $error("unlocked without first key");
  key_open_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (key_state == fpp_pkg::FPP_KEY_HALF && wr_key && reg_wdata_i == `FPP_KEY2)
    |=> key_open) else $error("key pair did not unlock");
  csr_locked_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (!key_open && seq == fpp_pkg::FPP_SEQ_IDLE) |=> !nvm_req_valid_o || $past(rop_clear_req))
    else $error("locked register started an operation");
  boot_mode_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(mode_taken) |-> boot_sysmem_o == (is_38 || is_35) && clk_force_rc_o == is_38)
    else $error("entry mode outputs wrong");
  mask_row_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    nvm_req_valid_o |-> ##1 seq == fpp_pkg::FPP_SEQ_WAIT && $stable(nvm_req_o))
    else $error("request not held");
  pin_reset_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> !prog_link_clock_pin_oe_o && prog_link_clock_pullup_o)
    else $error("link clock pin not input after reset");
endmodule // fpp_ctrl

// ---- hdl/fpp_consts.svh ----
/*
 Register offsets, field positions, reset values and entry counts for the
 program flash control block. Assumes an 8-bit register port.
*/
`ifndef FPP_CONSTS_SVH
`define FPP_CONSTS_SVH
`define FPP_ADDR_CSR 8'h00
`define FPP_ADDR_KEY 8'h01
`define FPP_ADDR_OPT 8'h02
`define FPP_ADDR_ADRH 8'h03
`define FPP_ADDR_ADRL 8'h04
`define FPP_ADDR_DATA 8'h05
`define FPP_ADDR_STAT 8'h06
`define FPP_ADDR_PIN 8'h07
`define FPP_CSR_RST 8'h00
`define FPP_CSR_PGM 0
`define FPP_CSR_LAT 1
`define FPP_CSR_SER 2
`define FPP_OPT_ROP 0
`define FPP_OPT_WEP 1
`define FPP_STAT_REFUSED 4
`define FPP_PIN_OE 0
`define FPP_PIN_LVL 1
`define FPP_KEY1 8'h56
`define FPP_KEY2 8'hAE
`define FPP_ENTRY_35 6'h23
`define FPP_ENTRY_38 6'h26
`define FPP_SETTLE 2'h3
`endif

// ---- hdl/fpp_pkg.sv ----
/*
 Types of the program flash control block. Assumes the constants header.
*/
package fpp_pkg;
  typedef enum logic [1:0] {
    FPP_MODE_APP = 2'h0,
    FPP_MODE_TOOL = 2'h1,
    FPP_MODE_SER35 = 2'h2,
    FPP_MODE_SER38 = 2'h3
  } fpp_mode_type;
  typedef enum logic [1:0] {
    FPP_OP_NONE = 2'h0,
    FPP_OP_PROG = 2'h1,
    FPP_OP_SECT = 2'h2,
    FPP_OP_MASS = 2'h3
  } fpp_op_type;
  typedef enum logic [1:0] {
    FPP_SEQ_IDLE = 2'h0,
    FPP_SEQ_ISSUE = 2'h1,
    FPP_SEQ_WAIT = 2'h3
  } fpp_state_type;
  typedef enum logic [1:0] {
    FPP_KEY_LOCKED = 2'h0,
    FPP_KEY_HALF = 2'h1,
    FPP_KEY_OPEN = 2'h3
  } fpp_key_type;
  typedef struct packed {
    fpp_op_type op;
    logic sector;
    logic [7:0] row;
    logic [31:0] mask;
    logic [255:0] data;
  } fpp_req_type;
endpackage

// ---- tb/fpp_tool_model.sv ----
/*
 Programming tool model: drives the link clock, link data and reset pins.
 Assumes the link clock idles high through the pin pull-up.
*/
`timescale 1ns/1ps
module fpp_tool_model (
  // link pins
  output logic link_clk_o,
  output logic rst_pin_n_o,
  output logic data_pin_o
);
  initial begin
    link_clk_o = 1'b1;
    rst_pin_n_o = 1'b1;
    data_pin_o = 1'b1;
  end
  task automatic pulse(input int n);
    repeat (n) begin
      #80 link_clk_o = 1'b0;
      #80 link_clk_o = 1'b1;
    end
  endtask
  // clock stands still outside frames; odd lead-in keeps phase unrelated
  task automatic entry(input int n);
    rst_pin_n_o = 1'b0;
    #37;
    pulse(2); // two edges carry the low reset level through the synchroniser
    pulse(n);
  endtask
  // edges with reset high let the entry counter clear
  task automatic leave();
    rst_pin_n_o = 1'b1;
    pulse(3);
  endtask
endmodule // fpp_tool_model

// ---- tb/testbench.sv ----
/*
 Self-checking bench: register tasks, flash array stub, scenarios.
 Assumes the tool model and the design compiled first.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"
module testbench;
  logic core_clk_i, resetn_i, link_resetn_i, socket_mode_i, nvm_done_i;
  logic reg_wr_i, reg_rd_i, lclk, rpin_n, dpin, pin_lvl, pin_oe, pin_pu;
  logic req_v, boot, frc, fext, xblk;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rdat;
  logic [12:0] a;
  fpp_pkg::fpp_req_type nvm_req_o, last_req;
  int errors = 0, n_checks = 0, nreq = 0;
  int pl[3] = '{35, 38, 20};
  logic [1:0] em[3] = '{2'h2, 2'h3, 2'h0};
  fpp_tool_model fpp_tool_model_i (.link_clk_o(lclk), .rst_pin_n_o(rpin_n),
    .data_pin_o(dpin));
  fpp_ctrl fpp_ctrl_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .link_clk_i(pin_oe ? pin_lvl : lclk), .link_resetn_i(link_resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rst_pin_n_i(rpin_n),
    .prog_link_data_pin_i(dpin), .socket_mode_i(socket_mode_i),
    .prog_link_clock_pin_o(pin_lvl), .prog_link_clock_pin_oe_o(pin_oe),
    .prog_link_clock_pullup_o(pin_pu), .nvm_req_o(nvm_req_o),
    .nvm_req_valid_o(req_v), .nvm_done_i(nvm_done_i), .boot_sysmem_o(boot),
    .clk_force_rc_o(frc), .clk_ext_sel_o(fext), .extract_block_o(xblk));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // array stub: slow answer, one request at a time
  always @(posedge core_clk_i) begin
    if (req_v === 1'b1) begin
      last_req <= nvm_req_o;
      nreq <= nreq + 1;
      repeat (6) @(posedge core_clk_i);
      nvm_done_i <= 1'b1;
      @(posedge core_clk_i);
      nvm_done_i <= 1'b0;
    end
  end
  task automatic chk(input string w, input logic [255:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  // strobe stays up between back-to-back writes; idle and rd drop it
  task automatic wr(input logic [7:0] ad, d);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_rd_i <= 1'b0;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
  endtask
  task automatic idle(input int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    reg_addr_i <= ad;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic rchk(input string w, input logic [7:0] ad, e);
    logic [7:0] d;
    rd(ad, d);
    chk(w, e, d);
  endtask
  task automatic op_run(input logic [7:0] ra, rv, input logic [12:0] ad,
                        input int nb, input logic ok, input fpp_pkg::fpp_op_type op);
    logic [255:0] d;
    logic [255:0] dm;
    logic [31:0] m;
    logic [7:0] b;
    int n0;
    d = '0;
    dm = '0;
    m = '0;
    n0 = nreq;
    if (nb > 0) wr(`FPP_ADDR_CSR, 8'h02);
    wr(`FPP_ADDR_ADRH, {3'h0, ad[12:8]});
    wr(`FPP_ADDR_ADRL, ad[7:0]);
    for (int i = 0; i < nb; i++) begin
      b = 8'($urandom);
      d[8 * (i + ad[4:0]) +: 8] = b;
      dm[8 * (i + ad[4:0]) +: 8] = 8'hFF;
      m[i + ad[4:0]] = 1'b1;
      wr(`FPP_ADDR_ADRL, ad[7:0] + 8'(i));
      wr(`FPP_ADDR_DATA, b);
    end
    wr(ra, rv);
    idle(1);
    for (int k = 0; k < 60 && nreq == n0; k++) @(posedge core_clk_i);
    idle(12);
    if (ok) begin
      chk("req count", n0 + 1, nreq);
      chk("req op", op, last_req.op);
      if (op != fpp_pkg::FPP_OP_MASS) chk("req sector", ad >= 13'h1000, last_req.sector);
      if (nb > 0) begin
        chk("req row", ad[12:5], last_req.row);
        chk("req mask", m, last_req.mask);
        chk("req data", d, last_req.data & dm);
      end
      rchk("csr done", `FPP_ADDR_CSR, 8'h00);
    end else begin
      chk("no req", n0, nreq);
      rd(`FPP_ADDR_STAT, b);
      chk("refused", 1'b1, b[`FPP_STAT_REFUSED]);
      wr(`FPP_ADDR_STAT, 8'h10);
      wr(`FPP_ADDR_CSR, 8'h00);
      idle(1);
    end
  endtask
  task automatic do_reset(input int pulses, input logic sock);
    idle(1);
    resetn_i <= 1'b0;
    socket_mode_i <= sock;
    if (pulses > 0) fpp_tool_model_i.entry(pulses);
    idle(10);
    resetn_i <= 1'b1;
    idle(6);
    fpp_tool_model_i.leave();
    idle(4);
  endtask
  task automatic unlock();
    wr(`FPP_ADDR_KEY, `FPP_KEY1);
    wr(`FPP_ADDR_KEY, `FPP_KEY2);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    summarize();
  end
  initial begin
    resetn_i = 1'b0;
    link_resetn_i = 1'b0;
    socket_mode_i = 1'b0;
    nvm_done_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    void'($urandom(32'h460acf20));
    #100 link_resetn_i = 1'b1;
    @(posedge core_clk_i);
    do_reset(0, 1'b0);
    rchk("csr reset", `FPP_ADDR_CSR, `FPP_CSR_RST);
    rchk("stat app", `FPP_ADDR_STAT, 8'h00);
    rchk("unmapped", 8'h3C, 8'h00);
    wr(`FPP_ADDR_CSR, 8'h02);
    rchk("csr locked", `FPP_ADDR_CSR, 8'h00);
    wr(`FPP_ADDR_KEY, `FPP_KEY2);
    wr(`FPP_ADDR_KEY, `FPP_KEY1);
    wr(`FPP_ADDR_ADRL, 8'h00);
    wr(`FPP_ADDR_KEY, `FPP_KEY2);
    rd(`FPP_ADDR_STAT, rdat);
    chk("bad keys", 1'b0, rdat[2]);
    unlock();
    rd(`FPP_ADDR_STAT, rdat);
    chk("keys", 1'b1, rdat[2]);
    wr(`FPP_ADDR_PIN, 8'h03);
    rchk("pin reg", `FPP_ADDR_PIN, 8'h03);
    idle(3);
    chk("pin drive", 3'b110, {pin_lvl, pin_oe, pin_pu});
    op_run(`FPP_ADDR_CSR, 8'h03, 13'h0040, 1, 1'b0, fpp_pkg::FPP_OP_PROG);
    op_run(`FPP_ADDR_CSR, 8'h04, 13'h0000, 0, 1'b0, fpp_pkg::FPP_OP_SECT);
    a = {1'b1, 7'($urandom), 5'h00};
    op_run(`FPP_ADDR_CSR, 8'h03, a, 32, 1'b1, fpp_pkg::FPP_OP_PROG);
    a = {1'b1, 12'($urandom)};
    op_run(`FPP_ADDR_CSR, 8'h03, a, 1, 1'b1, fpp_pkg::FPP_OP_PROG);
    do_reset(0, 1'b1);
    chk("pin reset", 2'b01, {pin_oe, pin_pu});
    unlock();
    rd(`FPP_ADDR_STAT, rdat);
    chk("tool mode", 2'h1, rdat[1:0]);
    op_run(`FPP_ADDR_CSR, 8'h03, 13'h0020, 32, 1'b1, fpp_pkg::FPP_OP_PROG);
    op_run(`FPP_ADDR_CSR, 8'h04, 13'h1000, 0, 1'b1, fpp_pkg::FPP_OP_SECT);
    op_run(`FPP_ADDR_CSR, 8'h04, 13'h0000, 0, 1'b1, fpp_pkg::FPP_OP_SECT);
    wr(`FPP_ADDR_OPT, 8'h01);
    rchk("rop only", `FPP_ADDR_OPT, 8'h01);
    chk("extract", 1'b1, xblk);
    op_run(`FPP_ADDR_CSR, 8'h03, 13'h1000, 1, 1'b0, fpp_pkg::FPP_OP_PROG);
    op_run(`FPP_ADDR_OPT, 8'h00, 13'h0000, 0, 1'b1, fpp_pkg::FPP_OP_MASS);
    rchk("rop off", `FPP_ADDR_OPT, 8'h00);
    chk("extract off", 1'b0, xblk);
    wr(`FPP_ADDR_OPT, 8'h02);
    rchk("wep only", `FPP_ADDR_OPT, 8'h02);
    chk("extract wep", 1'b0, xblk);
    op_run(`FPP_ADDR_CSR, 8'h03, 13'h1000, 1, 1'b0, fpp_pkg::FPP_OP_PROG);
    op_run(`FPP_ADDR_CSR, 8'h04, 13'h1000, 0, 1'b0, fpp_pkg::FPP_OP_SECT);
    wr(`FPP_ADDR_OPT, 8'h00);
    rchk("wep sticky", `FPP_ADDR_OPT, 8'h02);
    foreach (pl[i]) begin
      do_reset(pl[i], 1'b0);
      rd(`FPP_ADDR_STAT, rdat);
      chk("entry mode", em[i], rdat[1:0]);
      chk("boot vector", em[i] != 2'h0, boot);
      chk("force rc", em[i] == 2'h3, frc);
      chk("ext clock", em[i] == 2'h2, fext);
    end
    summarize();
  end
endmodule // testbench
